//--- frame_buffer_overflow_control.v
// Purpose : overflow supervision of the frame buffer input stream
// Assumes : fill level comes from buffer logic on the same clock; stream has no back-pressure
// Notes   : levels load on i_level_wr, values above 100.0% are clamped
//           the lost event of a refused frame leaves one cycle after its first beat
//           a cut frame gets no end-of-frame beat, only an incomplete tag
`timescale 1ns/10ps
`include "frame_overflow_defines.vh"

module frame_buffer_overflow_control (
  input  wire                   i_core_clk,
  input  wire                   i_rstn,
  input  wire                   i_ce,
  input  wire [`FILL_W-1:0]     i_fill_level,
  input  wire                   i_level_wr,
  input  wire [`LEVEL_W-1:0]    i_overflow_release_level,
  input  wire [`LEVEL_W-1:0]    i_overflow_entry_level,
  input  wire [`LEVEL_W-1:0]    i_frame_boundary_drop_level,
  input  wire [2:0]             i_frame_status_event_filter,
  input  wire                   i_overflow_rd,
  input  wire                   i_in_valid,
  input  wire                   i_in_sof,
  input  wire                   i_in_eof,
  input  wire [`DATA_W-1:0]     i_in_data,
  input  wire [`FRAME_ID_W-1:0] i_in_frame_identifier,
  output reg                    o_out_valid,
  output reg                    o_out_sof,
  output reg                    o_out_eof,
  output reg  [`DATA_W-1:0]     o_out_data,
  output reg                    o_tag_valid,
  output reg                    o_tag_incomplete,
  output reg  [`FRAME_ID_W-1:0] o_tag_frame_identifier,
  output reg                    o_overflow_flag,
  output reg                    o_overflow_active,
  output reg                    o_frame_refusing,
  output reg  [`FILL_W-1:0]     o_fill_level,
  output wire                   o_evt_valid,
  output wire [2:0]             o_evt_outcome,
  output wire [`FRAME_ID_W-1:0] o_evt_frame_identifier
);

  // =====================================================================
  // frame states
  // in ST_IDLE the block waits for a start of frame
  // in ST_PASS beats of an accepted frame are forwarded
  // in ST_DROP a frame refused at its start is swallowed
  // in ST_CUT the tail of a frame cut by overflow is swallowed
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PASS = 2'h1;
  localparam [1:0] ST_DROP = 2'h2;
  localparam [1:0] ST_CUT  = 2'h3;

  // =====================================================================
  // helpers
  // whole percent to half-percent units so fill compares exactly against 0.5% steps
  // 100 percent maps to 200, the top of the level range
  function [`LEVEL_W-1:0] to_half;
    input [`FILL_W-1:0] pct;
    begin
      to_half = {pct, 1'b0};
    end
  endfunction

  // software may write anything; keep levels inside 0.0..100.0 percent
  // an unclamped level above 200 could never be crossed by the fill
  function [`LEVEL_W-1:0] clamp_level;
    input [`LEVEL_W-1:0] lvl;
    begin
      clamp_level = (lvl > `LEVEL_MAX) ? `LEVEL_MAX : lvl;
    end
  endfunction

  // =====================================================================
  // reset release
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  // async assert, release through two flops so no flop leaves reset on a ragged edge
  // the synchroniser ignores i_ce so reset always completes
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // =====================================================================
  // level registers
  reg [`LEVEL_W-1:0] release_q;
  reg [`LEVEL_W-1:0] entry_q;
  reg [`LEVEL_W-1:0] drop_q;

  // reset to the default levels, reloaded by software
  // all three load together, so a partial update never mixes
  // an old entry level with a new release level
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      release_q <= `RELEASE_RESET;
      entry_q   <= `ENTRY_RESET;
      drop_q    <= `DROP_RESET;
    end else if (i_ce && i_level_wr) begin
      release_q <= clamp_level(i_overflow_release_level);
      entry_q   <= clamp_level(i_overflow_entry_level);
      drop_q    <= clamp_level(i_frame_boundary_drop_level);
    end
  end

  // =====================================================================
  // occupancy comparison and overflow state
  // comparisons act on the current fill, so entry takes effect in the same cycle
  wire [`FILL_W-1:0]  fill_pct;
  wire [`LEVEL_W-1:0] fill_half;
  wire                above_entry;
  wire                below_release;
  wire                above_drop;
  reg                 ovf_q;
  reg                 ovf_d;
  wire                ovf_enter;

  // fill above 100 percent cannot occur; clamp defensively
  assign fill_pct      = (i_fill_level > `FILL_MAX) ? `FILL_MAX : i_fill_level;
  assign fill_half     = to_half(fill_pct);
  assign above_entry   = fill_half > entry_q;
  assign below_release = fill_half < release_q;
  assign above_drop    = fill_half > drop_q;

  // hysteresis: enter above the entry level, leave only below the release level
  // limitation: a release level above the entry level makes the state toggle
  // while fill sits between them; software keeps release at or below entry
  always @* begin
    if (ovf_q) begin
      ovf_d = !below_release;
    end else begin
      ovf_d = above_entry;
    end
  end
  assign ovf_enter = ovf_d && !ovf_q;

  // state, sticky flag and readable occupancy
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q             <= 1'b0;
      o_overflow_flag   <= 1'b0;
      o_overflow_active <= 1'b0;
      o_frame_refusing  <= 1'b0;
      o_fill_level      <= {`FILL_W{1'b0}};
    end else if (i_ce) begin
      ovf_q             <= ovf_d;
      o_overflow_active <= ovf_d;
      o_frame_refusing  <= above_drop;
      o_fill_level      <= fill_pct;
      // a new entry in the read cycle wins, so no episode is lost
      // a read while i_ce is low is ignored, like every other input except i_rstn
      if (ovf_enter) begin
        o_overflow_flag <= 1'b1;
      end else if (i_overflow_rd) begin
        o_overflow_flag <= 1'b0;
      end
    end
  end

  // =====================================================================
  // frame sequencing
  // id_q keeps the id taken at sof; the id port is only valid with sof
  reg  [1:0]             state_q;
  reg  [1:0]             state_d;
  reg  [`FRAME_ID_W-1:0] id_q;
  wire                   beat;
  wire                   start;
  wire [`FRAME_ID_W-1:0] cur_id;
  reg                    pass_beat;
  reg                    close_tag;
  reg                    close_incomplete;
  reg                    evt_req;
  reg  [2:0]             evt_outcome;

  assign beat   = i_in_valid;
  assign start  = i_in_valid && i_in_sof;
  assign cur_id = start ? i_in_frame_identifier : id_q;

  // a start of frame always opens a new frame; a lost predecessor end is not repaired
  // refusal at sof and the cut both use the next overflow state, so
  // entry, cut and refusal all act on the same edge
  always @* begin
    state_d          = state_q;
    pass_beat        = 1'b0;
    close_tag        = 1'b0;
    close_incomplete = 1'b0;
    evt_req          = 1'b0;
    evt_outcome      = 3'h0;
    if (start) begin
      if (ovf_d || above_drop) begin
        // whole frame refused: nothing goes out, report it lost
        evt_req                = 1'b1;
        evt_outcome[`OUT_LOST] = 1'b1;
        state_d                = i_in_eof ? ST_IDLE : ST_DROP;
      end else begin
        // accepted: the drop level is not looked at again until the next sof
        pass_beat = 1'b1;
        if (i_in_eof) begin
          close_tag                 = 1'b1;
          evt_req                   = 1'b1;
          evt_outcome[`OUT_CORRECT] = 1'b1;
          state_d                   = ST_IDLE;
        end else begin
          state_d = ST_PASS;
        end
      end
    end else begin
      case (state_q)
        ST_PASS: begin
          if (ovf_d) begin
            // cut at once, even without a beat this cycle
            close_tag                    = 1'b1;
            close_incomplete             = 1'b1;
            evt_req                      = 1'b1;
            evt_outcome[`OUT_INCOMPLETE] = 1'b1;
            state_d                      = (beat && i_in_eof) ? ST_IDLE : ST_CUT;
          end else if (beat) begin
            pass_beat = 1'b1;
            if (i_in_eof) begin
              close_tag                 = 1'b1;
              evt_req                   = 1'b1;
              evt_outcome[`OUT_CORRECT] = 1'b1;
              state_d                   = ST_IDLE;
            end
          end
        end
        ST_DROP: begin
          // a refused frame may be long; only its end matters here
          if (beat && i_in_eof) begin
            state_d = ST_IDLE;
          end
        end
        ST_CUT: begin
          if (beat && i_in_eof) begin
            state_d = ST_IDLE;
          end
        end
        ST_IDLE: begin
          // beats without a start of frame are ignored
          state_d = ST_IDLE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // state, frame id and output stream registers
  // data loads only with a passing beat; o_out_data keeps the last passed
  // word while o_out_valid is low, which is harmless
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q                <= ST_IDLE;
      id_q                   <= {`FRAME_ID_W{1'b0}};
      o_out_valid            <= 1'b0;
      o_out_sof              <= 1'b0;
      o_out_eof              <= 1'b0;
      o_out_data             <= {`DATA_W{1'b0}};
      o_tag_valid            <= 1'b0;
      o_tag_incomplete       <= 1'b0;
      o_tag_frame_identifier <= {`FRAME_ID_W{1'b0}};
    end else if (i_ce) begin
      state_q     <= state_d;
      o_out_valid <= pass_beat;
      o_out_sof   <= pass_beat && i_in_sof;
      o_out_eof   <= pass_beat && i_in_eof;
      o_tag_valid <= close_tag;
      if (start) begin
        id_q <= i_in_frame_identifier;
      end
      if (pass_beat) begin
        o_out_data <= i_in_data;
      end
      if (close_tag) begin
        o_tag_incomplete       <= close_incomplete;
        o_tag_frame_identifier <= cur_id;
      end
    end
  end

  // =====================================================================
  // event filter
  // the filter registers the event, so it leaves one cycle after the beat that refuses
  // the frame or the cycle that closes it, together with the tag of a closed frame
  frame_event_filter u_event_filter (
    .i_core_clk                  (i_core_clk),
    .i_rst_n                     (rst_n),
    .i_ce                        (i_ce),
    .i_evt_req                   (evt_req),
    .i_evt_outcome               (evt_outcome),
    .i_evt_frame_identifier      (cur_id),
    .i_frame_status_event_filter (i_frame_status_event_filter),
    .o_evt_valid                 (o_evt_valid),
    .o_evt_outcome               (o_evt_outcome),
    .o_evt_frame_identifier      (o_evt_frame_identifier)
  );

endmodule // frame_buffer_overflow_control

//--- frame_overflow_defines.vh
// Purpose : constants for the frame buffer overflow supervisor
// Assumes : fill level is a whole percent 0..100, levels are in half-percent steps 0..200
// Notes   : header holds definitions only
//
// Overview of operation
// - overflow flag reads 1 when overflow was entered since the previous read
// - a read of the overflow flag clears it, unless overflow is entered in the same cycle
// - overflow state ends only when fill drops below the release level, default 50.0%
// - every frame arriving during overflow state is discarded
// - frames discarded during overflow are reported with the lost outcome
// - overflow state starts as soon as fill exceeds the entry level, default 99.5%
// - entering overflow cuts the running frame at once and tags it incomplete
// - above the drop level the running frame completes, later frames are refused
// - refused frames are accepted again once fill is at or below that level, no hysteresis
// - all three levels range 0.0 to 100.0 percent in 0.5 percent steps
// - a seven-way filter selects which frame outcomes raise events
// - each event carries the frame outcome and the frame identifier
// - occupancy is an integer percent 0..100, compared and readable
// - a wholly discarded frame produces no output transfer at all
`ifndef FRAME_OVERFLOW_DEFINES_VH
`define FRAME_OVERFLOW_DEFINES_VH

// =====================================================================
// widths
`define FILL_W          7
`define FILL_MAX        7'h64 // full buffer, whole percent
`define LEVEL_W         8
`define DATA_W          32
`define FRAME_ID_W      16

// =====================================================================
// level limits and reset values, in half-percent units
`define LEVEL_MAX       8'hc8
`define RELEASE_RESET   8'h64
`define ENTRY_RESET     8'hc7
`define DROP_RESET      8'ha0

// =====================================================================
// outcome bit positions; the filter code is a mask of these
`define OUT_INCOMPLETE  0
`define OUT_LOST        1
`define OUT_CORRECT     2
`define FILT_INCOMPLETE             3'h1
`define FILT_LOST                   3'h2
`define FILT_INCOMPLETE_OR_LOST     3'h3
`define FILT_CORRECT                3'h4
`define FILT_INCOMPLETE_OR_CORRECT  3'h5
`define FILT_LOST_OR_CORRECT        3'h6
`define FILT_ALL                    3'h7
`define FILTER_RESET    3'h7

`endif

//--- frame_event_filter.v
// Purpose : gate frame outcome events by the selected filter and register them
// Assumes : outcome is one-hot, one event per cycle at most
// Notes   : filter code 0 raises nothing
`timescale 1ns/10ps
`include "frame_overflow_defines.vh"

module frame_event_filter (
  input  wire                   i_core_clk,
  input  wire                   i_rst_n,
  input  wire                   i_ce,
  input  wire                   i_evt_req,
  input  wire [2:0]             i_evt_outcome,
  input  wire [`FRAME_ID_W-1:0] i_evt_frame_identifier,
  input  wire [2:0]             i_frame_status_event_filter,
  output reg                    o_evt_valid,
  output reg  [2:0]             o_evt_outcome,
  output reg  [`FRAME_ID_W-1:0] o_evt_frame_identifier
);

  // =====================================================================
  // filter and event register
  wire pass_evt;

  // the filter code is a mask over the one-hot outcome
  assign pass_evt = i_evt_req && ((i_evt_outcome & i_frame_status_event_filter) != 3'h0);

  // outcome and identifier travel together in one pulse
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_evt_valid            <= 1'b0;
      o_evt_outcome          <= 3'h0;
      o_evt_frame_identifier <= {`FRAME_ID_W{1'b0}};
    end else if (i_ce) begin
      o_evt_valid <= pass_evt;
      if (pass_evt) begin
        o_evt_outcome          <= i_evt_outcome;
        o_evt_frame_identifier <= i_evt_frame_identifier;
      end
    end
  end

endmodule // frame_event_filter

//--- frame_overflow_props.sv
// Purpose : port assertions for the frame buffer overflow supervisor
// Assumes : clock enable gates the read and copy checks
// Notes   : up_q waits out the two-flop reset copy before fill checks
`timescale 1ns/10ps
`include "frame_overflow_defines.vh"
module frame_overflow_props (
  input wire               i_core_clk,
  input wire               i_rstn,
  input wire               i_ce,
  input wire [`FILL_W-1:0] i_fill_level,
  input wire [2:0]         i_frame_status_event_filter,
  input wire               i_overflow_rd,
  input wire               o_out_valid,
  input wire               o_out_eof,
  input wire               o_tag_valid,
  input wire               o_tag_incomplete,
  input wire               o_overflow_flag,
  input wire               o_overflow_active,
  input wire [`FILL_W-1:0] o_fill_level,
  input wire               o_evt_valid,
  input wire [2:0]         o_evt_outcome
);
  reg [2:0] up_q;
  // ===========================================================
  // helper: edges since reset release
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) up_q <= 3'h0;
    else up_q <= {up_q[1:0], 1'b1};
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ===========================================================
  // assertions
  chk_flag_on_entry: assert property ($rose(o_overflow_active) |-> o_overflow_flag)
    else $error("flag not set on entry");
  chk_read_clears: assert property (
    i_ce && i_overflow_rd && o_overflow_active |=> !o_overflow_flag)
    else $error("read left flag set");
  chk_flag_sticky: assert property (o_overflow_flag && !i_overflow_rd |=> o_overflow_flag)
    else $error("flag dropped without read");
  chk_no_out_ovf: assert property (o_overflow_active |-> !o_out_valid)
    else $error("beat passed in overflow");
  chk_cut_at_entry: assert property (
    o_tag_valid && o_tag_incomplete |-> $rose(o_overflow_active) && !o_out_eof)
    else $error("incomplete tag off entry");
  chk_eof_tag_ok: assert property (o_out_eof |-> o_tag_valid && !o_tag_incomplete)
    else $error("eof without correct tag");
  chk_evt_onehot: assert property (o_evt_valid |-> $onehot(o_evt_outcome))
    else $error("event outcome not one-hot");
  chk_evt_filter: assert property (
    o_evt_valid |-> (o_evt_outcome & $past(i_frame_status_event_filter)) != 3'h0)
    else $error("event passed closed filter");
  chk_fill_copy: assert property (
    up_q[2] && $past(i_ce) |->
    o_fill_level == ($past(i_fill_level) > 7'h64 ? 7'h64 : $past(i_fill_level)))
    else $error("fill level copy wrong");
endmodule // frame_overflow_props

bind frame_buffer_overflow_control frame_overflow_props u_props (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_fill_level(i_fill_level),
  .i_frame_status_event_filter(i_frame_status_event_filter), .i_overflow_rd(i_overflow_rd),
  .o_out_valid(o_out_valid), .o_out_eof(o_out_eof), .o_tag_valid(o_tag_valid),
  .o_tag_incomplete(o_tag_incomplete), .o_overflow_flag(o_overflow_flag),
  .o_overflow_active(o_overflow_active), .o_fill_level(o_fill_level),
  .o_evt_valid(o_evt_valid), .o_evt_outcome(o_evt_outcome));

//--- camera_stream_src.sv
// Purpose : camera stream and buffer fill source
// Assumes : one beat per clock, no back-pressure
// Notes   : id only valid with sof; data inverted when idle
`timescale 1ns/10ps
`include "frame_overflow_defines.vh"
module camera_stream_src (
  input  wire                   i_core_clk,
  output reg                    o_valid,
  output reg                    o_sof,
  output reg                    o_eof,
  output reg  [`DATA_W-1:0]     o_data,
  output reg  [`FRAME_ID_W-1:0] o_id,
  output reg  [`FILL_W-1:0]     o_fill
);
  initial begin
    {o_valid, o_sof, o_eof, o_data, o_id, o_fill} = 0;
  end
  // ===========================================================
  // one frame; fill f0 on the first beat and f1 after it
  task send(input integer len, input [15:0] id, input [6:0] f0, input [6:0] f1);
    integer i;
    begin
      for (i = 0; i < len; i = i + 1) begin
        @(posedge i_core_clk);
        o_valid <= 1'b1;
        o_sof   <= (i == 0);
        o_eof   <= (i == len - 1);
        o_data  <= {id, i[15:0]};
        o_id    <= (i == 0) ? id : ~id; // garbage off sof
        o_fill  <= (i == 0) ? f0 : f1;
      end
      @(posedge i_core_clk);
      {o_valid, o_sof, o_eof} <= 3'h0;
      o_data  <= ~o_data; // idle bus must not look like a beat
    end
  endtask
endmodule // camera_stream_src

//--- tb.sv
// Purpose : self-checking bench of the overflow supervisor
// Assumes : clock enable high except for the freeze check in rdchk
// Notes   : expectations queued at drive time, popped by the monitor
`timescale 1ns/10ps
`include "frame_overflow_defines.vh"
module tb;
  reg                    clk, rstn, lvl_wr, rd, ce;
  reg  [`LEVEL_W-1:0]    rel, ent, drp, mrel, ment, mdrp;
  reg  [2:0]             filt, fm;
  reg                    act, flgx;
  wire                   iv, isof, ieof, ov, osof, oeof, tv, tinc, flg, acto, ev, refo;
  wire [`DATA_W-1:0]     idat, odat;
  wire [`FRAME_ID_W-1:0] iid, tid, eid;
  wire [`FILL_W-1:0]     fill;
  wire [2:0]             eout;
  integer                miscompares, n_compared, cyc, f;
  reg  [33:0]            qo[$];
  reg  [18:0]            qe[$];
  reg  [16:0]            qt[$];
  camera_stream_src cam (.i_core_clk(clk), .o_valid(iv), .o_sof(isof), .o_eof(ieof),
    .o_data(idat), .o_id(iid), .o_fill(fill));
  frame_buffer_overflow_control DUT (.i_core_clk(clk), .i_rstn(rstn), .i_ce(ce),
    .i_fill_level(fill), .i_level_wr(lvl_wr), .i_overflow_release_level(rel),
    .i_overflow_entry_level(ent), .i_frame_boundary_drop_level(drp),
    .i_frame_status_event_filter(filt), .i_overflow_rd(rd), .i_in_valid(iv),
    .i_in_sof(isof), .i_in_eof(ieof), .i_in_data(idat), .i_in_frame_identifier(iid),
    .o_out_valid(ov), .o_out_sof(osof), .o_out_eof(oeof), .o_out_data(odat),
    .o_tag_valid(tv), .o_tag_incomplete(tinc), .o_tag_frame_identifier(tid),
    .o_overflow_flag(flg), .o_overflow_active(acto), .o_frame_refusing(refo),
    .o_fill_level(), .o_evt_valid(ev), .o_evt_outcome(eout), .o_evt_frame_identifier(eid));
  // ===========================================================
  // clock, compare, closing
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input [63:0] e, input [63:0] g, input [8*9-1:0] nm);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task summarize;
    begin
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // monitor: each result takes the oldest note of its kind
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (ov === 1'b1) chk(qo.size() ? qo.pop_front() : 0, {osof, oeof, odat}, "out_beat");
    if (ev === 1'b1) chk(qe.size() ? qe.pop_front() : 0, {eout, eid}, "event");
    if (tv === 1'b1) chk(qt.size() ? qt.pop_front() : 0, {tinc, tid}, "tag");
    // the ceiling is the last thing done here, so nothing follows the end of the run
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  // ===========================================================
  // reference model of state, flag and frame outcome
  function [7:0] dbl(input [6:0] v);
    dbl = {((v > 7'h64) ? 7'h64 : v), 1'b0};
  endfunction
  task upd(input [6:0] v);
    begin
      if (dbl(v) > ment) begin
        if (!act) flgx = 1'b1;
        act = 1'b1;
      end else if (dbl(v) < mrel) act = 1'b0;
    end
  endtask
  task evq(input [2:0] c, input [15:0] id);
    if (fm & c) qe.push_back({c, id});
  endtask
  task frame(input integer len, input [6:0] f0, input [6:0] f1);
    reg [15:0] id;
    reg        dead;
    integer    i;
    begin
      id = $urandom;
      dead = 1'b0;
      for (i = 0; i < len; i = i + 1) begin
        upd(i == 0 ? f0 : f1);
        if (i == 0) begin
          dead = act || dbl(f0) > mdrp;
          if (dead) evq(3'h2, id);
        end else if (act && !dead) begin
          dead = 1'b1;
          qt.push_back({1'b1, id});
          evq(3'h1, id);
        end
        if (!dead) qo.push_back({i == 0, i == len - 1, id, i[15:0]});
        if (!dead && i == len - 1) begin
          qt.push_back({1'b0, id});
          evq(3'h4, id);
        end
      end
      cam.send(len, id, f0, f1);
    end
  endtask
  task lv(input [7:0] r, input [7:0] e, input [7:0] d);
    begin
      @(posedge clk);
      {rel, ent, drp, lvl_wr} <= {r, e, d, 1'b1};
      @(posedge clk);
      lvl_wr <= 1'b0;
      mrel = (r > 8'hc8) ? 8'hc8 : r;
      ment = (e > 8'hc8) ? 8'hc8 : e;
      mdrp = (d > 8'hc8) ? 8'hc8 : d;
    end
  endtask
  task rdchk;
    begin
      repeat (3) @(posedge clk);
      chk(flgx, flg, "ovf_flag");
      chk(act, acto, "ovf_state");
      chk(dbl(fill) > mdrp, refo, "refusing");
      // a read while the clock enable is low must leave the flag alone
      {ce, rd} <= 2'h1;
      @(posedge clk);
      {ce, rd} <= 2'h2;
      @(posedge clk);
      chk(flgx, flg, "ce_freeze");
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      flgx = 1'b0;
      @(posedge clk);
      #1 chk(0, flg, "flag_read");
    end
  endtask
  // ===========================================================
  // main sequence
  initial begin
    {rstn, lvl_wr, rd, act, flgx, ce} = 6'h1;
    {rel, ent, drp} = {8'h64, 8'hc7, 8'ha0};
    {mrel, ment, mdrp} = {8'h64, 8'hc7, 8'ha0};
    {filt, fm} = {3'h7, 3'h7};
    {miscompares, n_compared, cyc} = 0;
    f = $urandom(57);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    // default levels at their boundaries
    frame(2, 80, 80);
    frame(3, 81, 81);
    frame(2, 99, 99);
    frame(3, 40, 100);
    rdchk;
    frame(2, 60, 60);
    frame(1, 50, 50);
    frame(2, 49, 49);
    rdchk;
    // every filter choice against every outcome
    for (f = 0; f < 8; f = f + 1) begin
      @(posedge clk);
      filt <= f;
      fm = f;
      frame(1 + $urandom % 4, 10, 10);
      frame(1 + $urandom % 4, 90, 90);
      frame(2 + $urandom % 3, 10, 100);
      frame(2, 20, 20);
      rdchk;
    end
    // programmed levels, no hysteresis on the drop level
    lv(8'h28, 8'h96, 8'h64);
    frame(2, 50, 50);
    frame(2, 51, 51);
    frame(2, 50, 50);
    frame(3, 20, 76);
    frame(2, 21, 21);
    frame(2, 19, 19);
    rdchk;
    // levels above full scale clamp to 100.0 percent
    lv(8'hff, 8'hff, 8'hff);
    frame(2, 127, 127);
    repeat (5) @(posedge clk);
    chk(0, qo.size() + qe.size() + qt.size(), "left_over");
    summarize;
  end
endmodule // tb
